// File: inc/rpc_pkg.sv
// Constants and types for the receiver port capability register bank
package rpc_pkg;

    // ==========================================================
    // Bus and bank geometry
    // ==========================================================
    localparam int ADDR_W   = 20;
    localparam int DATA_W   = 8;
    localparam int NUM_DSP  = 16;
    localparam int DSP_IDX_W = 4;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [19:0] OFS_RX0_CAP_A   = 20'h00008;
    localparam logic [19:0] OFS_RX0_CAP_B   = 20'h00009;
    localparam logic [19:0] OFS_RX1_CAP_A   = 20'h0000A;
    localparam logic [19:0] OFS_RX1_CAP_B   = 20'h0000B;
    localparam logic [19:0] OFS_GAP_FIRST   = 20'h0000C;
    localparam logic [19:0] OFS_GAP_LAST    = 20'h0007F;
    localparam logic [19:0] OFS_DSP_BASE    = 20'h00080;
    localparam logic [19:0] OFS_DSP_LAST    = 20'h0008F;
    localparam logic [19:0] OFS_RSVD_FIRST  = 20'h00090;
    localparam logic [19:0] OFS_RSVD_LAST   = 20'h000FF;

    // ==========================================================
    // Field positions in the first receive-port byte
    // ==========================================================
    localparam int RXA_OWN_TABLE_BIT = 1;
    localparam int RXA_SECONDARY_BIT = 2;

    // ==========================================================
    // Field positions in a downstream port byte
    // ==========================================================
    localparam int DSP_KIND_LSB   = 0;
    localparam int DSP_KIND_W     = 3;
    localparam int DSP_HOTPLUG_BIT = 3;

    // ==========================================================
    // Buffer size arithmetic
    // ==========================================================
    localparam int BUF_UNIT_BYTES = 32;
    localparam int BUF_BYTES_W    = 14;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Downstream port kinds
    // ==========================================================
    typedef enum logic [2:0] {
        RPC_KIND_NATIVE = 3'h0,
        RPC_KIND_VGA    = 3'h1,
        RPC_KIND_DVI    = 3'h2,
        RPC_KIND_TV     = 3'h3,
        RPC_KIND_OTHER  = 3'h4
    } rpc_kind_type;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rpc_bus_req_type;

    typedef struct packed {
        logic       cfg_v11;
        logic       sink_or_converter;
        logic       rx0_own_table;
        logic [7:0] rx0_buffer_code;
        logic       rx1_present;
        logic       rx1_own_table;
        logic       rx1_secondary;
        logic [7:0] rx1_buffer_code;
        logic [3:0] downstream_port_total;
    } rpc_cfg_type;

    typedef struct packed {
        logic [2:0] downstream_port_kind;
        logic       native_hotplug;
        logic       own_hotplug_method;
    } rpc_dsp_cfg_type;

endpackage

// File: verilog/rpc_dsp_byte.sv
// One downstream port capability byte built from its configuration
`timescale 1ns/10ps
module rpc_dsp_byte
    import rpc_pkg::*;
#(
    parameter int PORT_IDX = 0
) (
    input  wire rpc_pkg::rpc_dsp_cfg_type dsp_cfg,
    input  wire logic [3:0]               port_total,
    input  wire logic                     cfg_v11,
    output logic [7:0]                    cap_byte
);

    logic [2:0] kind_clean;
    logic       present;

    // ==========================================================
    // Port kind, reserved codes folded to the generic kind
    // ==========================================================
    always_comb begin
        if (dsp_cfg.downstream_port_kind > RPC_KIND_OTHER) begin
            kind_clean = RPC_KIND_OTHER;
        end else begin
            kind_clean = dsp_cfg.downstream_port_kind;
        end
    end

    // Ports past the count and older version show nothing
    assign present = cfg_v11 && (PORT_IDX < int'(port_total));

    // ==========================================================
    // Byte assembly
    // ==========================================================
    always_comb begin
        cap_byte = BYTE_ZERO;
        if (present) begin
            cap_byte[DSP_KIND_LSB +: DSP_KIND_W] = kind_clean;
            // Own polling counts as awareness too
            cap_byte[DSP_HOTPLUG_BIT] = dsp_cfg.native_hotplug
                                        | dsp_cfg.own_hotplug_method;
        end
    end

endmodule

// File: verilog/rpc_cap_bank.sv
// Receiver port capability register bank: read-only capability bytes
//
// Summary of operation
// - Port 0 first byte returns zero in bit 0 and bits 7:3.
// - Bit 1 reads 1 when the receiver port has its own identification table.
// - Sink or format converter always reports its own table present.
// - Bit 2 reads 1 for a secondary stream tied to the preceding port.
// - Receiver port 0 always reports the secondary-stream bit as zero.
// - Receiver port 0 reports bit 3 of its first byte as zero.
// - Second byte is a buffer code; per-lane bytes are (code+1)*32, max 8K.
// - Port 1 bytes share port 0 layout and read zero when port 1 is absent.
// - One downstream capability byte per port, at 80h plus port number.
// - Bits 2:0 give port kind; codes 101 to 111 are reserved.
// - Bit 3 reads 1 when the downstream port is hot-plug aware.
// - Own detection method, such as table polling, also sets bit 3.
// - Bits 7:4 of each downstream byte read zero.
// - Addresses 90h to FFh are reserved and read zero.
// - Under version 1.0 the bytes 80h to 8Fh read zero.
// - A 4-bit count gives the downstream ports; zero when none exist.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module rpc_cap_bank
    import rpc_pkg::*;
#(
    parameter int NUM_PORTS = rpc_pkg::NUM_DSP
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire rpc_pkg::rpc_bus_req_type   bus_req,
    output logic [rpc_pkg::DATA_W-1:0]      rd_data,
    input  wire rpc_pkg::rpc_cfg_type       cfg,
    input  wire rpc_pkg::rpc_dsp_cfg_type   dsp_cfg [NUM_PORTS],
    output logic [rpc_pkg::BUF_BYTES_W-1:0] rx0_lane_buffer_bytes,
    output logic [rpc_pkg::BUF_BYTES_W-1:0] rx1_lane_buffer_bytes
);

    // ==========================================================
    // Address decode and lane buffer size helpers
    // ==========================================================
    function automatic logic in_range(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] lo,
        input logic [ADDR_W-1:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [BUF_BYTES_W-1:0] lane_bytes(
        input logic [7:0] code
    );
        logic [BUF_BYTES_W-1:0] units;
        units = BUF_BYTES_W'(code) + BUF_BYTES_W'(1);
        // Code 255 lands exactly on the 8K ceiling
        lane_bytes = BUF_BYTES_W'(units * BUF_BYTES_W'(BUF_UNIT_BYTES));
    endfunction

    // ==========================================================
    // Storage
    // ==========================================================
    logic [7:0]             rx0_cap_a_r;
    logic [7:0]             rx0_cap_b_r;
    logic [7:0]             rx1_cap_a_r;
    logic [7:0]             rx1_cap_b_r;
    logic [7:0]             dsp_cap_r [NUM_PORTS];
    logic [7:0]             dsp_cap_nxt [NUM_PORTS];
    logic [7:0]             rx0_cap_a_nxt;
    logic [7:0]             rx1_cap_a_nxt;
    logic [DATA_W-1:0]      rd_data_r;
    logic [DATA_W-1:0]      rd_data_nxt;
    logic [BUF_BYTES_W-1:0] rx0_bytes_r;
    logic [BUF_BYTES_W-1:0] rx1_bytes_r;
    logic [DSP_IDX_W-1:0]   dsp_idx;

    assign rd_data               = rd_data_r;
    assign rx0_lane_buffer_bytes = rx0_bytes_r;
    assign rx1_lane_buffer_bytes = rx1_bytes_r;

    // ==========================================================
    // Receiver port 0 first byte
    // ==========================================================
    always_comb begin
        rx0_cap_a_nxt = BYTE_ZERO;
        rx0_cap_a_nxt[RXA_OWN_TABLE_BIT] = cfg.rx0_own_table
                                           | cfg.sink_or_converter;
        // Port 0 never carries a secondary stream
        rx0_cap_a_nxt[RXA_SECONDARY_BIT] = 1'b0;
    end

    // ==========================================================
    // Receiver port 1 first byte
    // ==========================================================
    always_comb begin
        rx1_cap_a_nxt = BYTE_ZERO;
        if (cfg.rx1_present) begin
            rx1_cap_a_nxt[RXA_OWN_TABLE_BIT] = cfg.rx1_own_table
                                               | cfg.sink_or_converter;
            rx1_cap_a_nxt[RXA_SECONDARY_BIT] = cfg.rx1_secondary;
        end
    end

    // ==========================================================
    // Receiver capability bytes, sampled every cycle
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx0_cap_a_r <= 8'h00;
            rx0_cap_b_r <= 8'h00;
            rx1_cap_a_r <= 8'h00;
            rx1_cap_b_r <= 8'h00;
        end else begin
            rx0_cap_a_r <= rx0_cap_a_nxt;
            rx0_cap_b_r <= cfg.rx0_buffer_code;
            rx1_cap_a_r <= rx1_cap_a_nxt;
            rx1_cap_b_r <= cfg.rx1_present ? cfg.rx1_buffer_code
                                           : BYTE_ZERO;
        end
    end

    // ==========================================================
    // Per-lane buffer sizes for the receive datapath
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx0_bytes_r <= 14'h0000;
            rx1_bytes_r <= 14'h0000;
        end else begin
            rx0_bytes_r <= lane_bytes(cfg.rx0_buffer_code);
            rx1_bytes_r <= cfg.rx1_present ? lane_bytes(cfg.rx1_buffer_code)
                                           : 14'h0000;
        end
    end

    // ==========================================================
    // Downstream port bytes
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_dsp
            rpc_dsp_byte #(
                .PORT_IDX   (gi)
            ) u_byte (
                .dsp_cfg    (dsp_cfg[gi]),
                .port_total (cfg.downstream_port_total),
                .cfg_v11    (cfg.cfg_v11),
                .cap_byte   (dsp_cap_nxt[gi])
            );

            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    dsp_cap_r[gi] <= 8'h00;
                end else begin
                    dsp_cap_r[gi] <= dsp_cap_nxt[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read decode
    // ==========================================================
    assign dsp_idx = bus_req.addr[DSP_IDX_W-1:0];

    always_comb begin
        rd_data_nxt = BYTE_ZERO;
        case (1'b1)
            (bus_req.addr == OFS_RX0_CAP_A): begin
                rd_data_nxt = rx0_cap_a_r;
            end
            (bus_req.addr == OFS_RX0_CAP_B): begin
                rd_data_nxt = rx0_cap_b_r;
            end
            (bus_req.addr == OFS_RX1_CAP_A): begin
                rd_data_nxt = rx1_cap_a_r;
            end
            (bus_req.addr == OFS_RX1_CAP_B): begin
                rd_data_nxt = rx1_cap_b_r;
            end
            in_range(bus_req.addr, OFS_GAP_FIRST, OFS_GAP_LAST): begin
                rd_data_nxt = BYTE_ZERO;
            end
            in_range(bus_req.addr, OFS_DSP_BASE, OFS_DSP_LAST): begin
                // Slots beyond the built ports read zero
                if (int'(dsp_idx) < NUM_PORTS) begin
                    rd_data_nxt = dsp_cap_r[dsp_idx];
                end
            end
            in_range(bus_req.addr, OFS_RSVD_FIRST, OFS_RSVD_LAST): begin
                rd_data_nxt = BYTE_ZERO;
            end
            default: begin
                rd_data_nxt = BYTE_ZERO;
            end
        endcase
    end

    // ==========================================================
    // Read data: valid only in the cycle after the strobe
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_data_r <= 8'h00;
        end else if (bus_req.rd) begin
            rd_data_r <= rd_data_nxt;
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    // Write strobe and data are deliberately unused:
    // capability bytes only follow configuration

endmodule

// File: tb/rpc_cap_bank_sva.sv
// Checker for the receiver port capability register bank
`timescale 1ns/10ps
module rpc_cap_bank_sva
    import rpc_pkg::*;
#(
    parameter int NUM_PORTS = 16
) (
    input wire logic                          clk_sys,
    input wire logic                          rst_b,
    input wire rpc_pkg::rpc_bus_req_type      bus_req,
    input wire logic [rpc_pkg::DATA_W-1:0]    rd_data,
    input wire rpc_pkg::rpc_cfg_type          cfg,
    input wire rpc_pkg::rpc_dsp_cfg_type      dsp_cfg [NUM_PORTS],
    input wire logic [rpc_pkg::BUF_BYTES_W-1:0] rx0_lane_buffer_bytes,
    input wire logic [rpc_pkg::BUF_BYTES_W-1:0] rx1_lane_buffer_bytes
);
    // ==========================================================
    // Helpers
    // ==========================================================
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    rpc_cfg_type prev_cfg_r;
    logic        prev_rst_r;
    logic [19:0] a;
    logic        ok;
    logic [7:0]  dsp_exp;
    // Expected downstream byte for the addressed slot, reserved kinds shown as other
    always_comb begin
        dsp_exp = 8'h00;
        if (int'(a[3:0]) < NUM_PORTS) begin
            dsp_exp[3] = dsp_cfg[a[3:0]].native_hotplug | dsp_cfg[a[3:0]].own_hotplug_method;
            dsp_exp[2:0] = (dsp_cfg[a[3:0]].downstream_port_kind > 3'h4) ? 3'h4
                                                                         : dsp_cfg[a[3:0]].downstream_port_kind;
        end
    end
    always_ff @(posedge clk_sys) begin
        prev_cfg_r <= cfg;
        prev_rst_r <= rst_b;
    end
    assign a = bus_req.addr;
    // Config held a cycle, so the bytes read back reflect it
    assign ok = bus_req.rd && (cfg == prev_cfg_r) && prev_rst_r;
    // ==========================================================
    // Properties
    // ==========================================================
    property p_rx0_fixed;
        ok && a == OFS_RX0_CAP_A |=> (rd_data & 8'hFD) == 8'h00;
    endproperty
    a_rx0_fixed: assert property (p_rx0_fixed) else $error("port0 first byte reserved bits set");
    property p_rx0_own;
        ok && a == OFS_RX0_CAP_A |=> rd_data[1] == (prev_cfg_r.rx0_own_table | prev_cfg_r.sink_or_converter);
    endproperty
    a_rx0_own: assert property (p_rx0_own) else $error("port0 own table bit wrong");
    property p_rx0_buf;
        ok && a == OFS_RX0_CAP_B |=> rd_data == prev_cfg_r.rx0_buffer_code;
    endproperty
    a_rx0_buf: assert property (p_rx0_buf) else $error("port0 buffer code wrong");
    property p_rx1_gone;
        ok && !cfg.rx1_present && (a == OFS_RX1_CAP_A || a == OFS_RX1_CAP_B) |=> rd_data == 8'h00;
    endproperty
    a_rx1_gone: assert property (p_rx1_gone) else $error("absent port1 byte not zero");
    property p_rx1_sec;
        ok && cfg.rx1_present && a == OFS_RX1_CAP_A |=> rd_data[2] == prev_cfg_r.rx1_secondary;
    endproperty
    a_rx1_sec: assert property (p_rx1_sec) else $error("port1 secondary stream bit wrong");
    property p_dsp_byte;
        ok && cfg.cfg_v11 && a >= OFS_DSP_BASE && a <= OFS_DSP_LAST && a[3:0] < cfg.downstream_port_total
            |=> rd_data == $past(dsp_exp);
    endproperty
    a_dsp_byte: assert property (p_dsp_byte) else $error("downstream byte content wrong");
    property p_rsvd;
        bus_req.rd && ((a >= OFS_GAP_FIRST && a <= OFS_GAP_LAST) || a >= OFS_RSVD_FIRST) |=> rd_data == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved address not zero");
    property p_dsp_hi;
        bus_req.rd && a >= OFS_DSP_BASE && a <= OFS_DSP_LAST |=> rd_data[7:4] == 4'h0;
    endproperty
    a_dsp_hi: assert property (p_dsp_hi) else $error("downstream upper bits set");
    property p_v10;
        ok && !cfg.cfg_v11 && a >= OFS_DSP_BASE && a <= OFS_DSP_LAST |=> rd_data == 8'h00;
    endproperty
    a_v10: assert property (p_v10) else $error("old layout downstream byte not zero");
    property p_past_total;
        ok && a >= OFS_DSP_BASE && a <= OFS_DSP_LAST && a[3:0] >= cfg.downstream_port_total |=> rd_data == 8'h00;
    endproperty
    a_past_total: assert property (p_past_total) else $error("unbuilt downstream byte not zero");
    property p_wr_quiet;
        bus_req.wr && !bus_req.rd |=> rd_data == 8'h00;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write showed on read data");
    property p_buf_bytes;
        prev_rst_r && cfg == prev_cfg_r |-> rx0_lane_buffer_bytes == ({6'h00, cfg.rx0_buffer_code} + 14'h0001) << 5;
    endproperty
    a_buf_bytes: assert property (p_buf_bytes) else $error("port0 lane buffer size wrong");
    c_dsp: cover property (ok && a == OFS_DSP_BASE);
    c_rx1_gone: cover property (ok && !cfg.rx1_present && a == OFS_RX1_CAP_A);
    c_wr: cover property (bus_req.wr);
endmodule

// File: tb/rpc_src_model.sv
// Source side model issuing register reads and writes
`timescale 1ns/10ps
module rpc_src_model
    import rpc_pkg::*;
(
    input wire logic               clk_sys,
    output rpc_pkg::rpc_bus_req_type bus_req
);
    initial bus_req = '0;
    // One strobe per cycle; the slave never stalls
    task automatic xfer(input logic rd, input logic wr, input logic [19:0] a, input logic [7:0] d);
        bus_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge clk_sys);
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the capability register bank
`timescale 1ns/10ps
module tb_top;
    import rpc_pkg::*;
    localparam int NP = 16;
    logic            clk_sys;
    logic            rst_b;
    rpc_bus_req_type bus_req;
    logic [7:0]      rd_data;
    rpc_cfg_type     cfg;
    rpc_dsp_cfg_type dsp_cfg [NP];
    logic [13:0]     rx0_bytes;
    logic [13:0]     rx1_bytes;
    logic [7:0]      exp_q [$];
    logic            rd_seen;
    int              error_cnt;
    int              checks_done;
    int              seed;
    // ==========================================================
    // Clock, partner and design
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    rpc_src_model src (.clk_sys(clk_sys), .bus_req(bus_req));
    rpc_cap_bank #(.NUM_PORTS(NP)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .cfg(cfg), .dsp_cfg(dsp_cfg), .rx0_lane_buffer_bytes(rx0_bytes), .rx1_lane_buffer_bytes(rx1_bytes));
    // ==========================================================
    // Checking
    // ==========================================================
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t read byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check14(input logic [13:0] got, input logic [13:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t buffer size got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [19:0] a);
        logic [3:0] i;
        logic [2:0] k;
        i = a[3:0];
        k = dsp_cfg[i].downstream_port_kind;
        exp_byte = 8'h00;
        if (a == OFS_RX0_CAP_A) exp_byte = {6'h00, cfg.rx0_own_table | cfg.sink_or_converter, 1'b0};
        else if (a == OFS_RX0_CAP_B) exp_byte = cfg.rx0_buffer_code;
        else if (a == OFS_RX1_CAP_A && cfg.rx1_present)
            exp_byte = {5'h00, cfg.rx1_secondary, cfg.rx1_own_table | cfg.sink_or_converter, 1'b0};
        else if (a == OFS_RX1_CAP_B && cfg.rx1_present) exp_byte = cfg.rx1_buffer_code;
        else if (a >= OFS_DSP_BASE && a <= OFS_DSP_LAST && cfg.cfg_v11 && i < cfg.downstream_port_total)
            exp_byte = {4'h0, dsp_cfg[i].native_hotplug | dsp_cfg[i].own_hotplug_method, k > 3'h4 ? 3'h4 : k};
    endfunction
    always @(posedge clk_sys) rd_seen <= bus_req.rd && rst_b;
    always @(negedge clk_sys) begin
        if (rd_seen && exp_q.size() > 0) check8(rd_data, exp_q.pop_front());
    end
    // ==========================================================
    // Stimulus
    // ==========================================================
    task automatic rd(input logic [19:0] a);
        exp_q.push_back(exp_byte(a));
        src.xfer(1'b1, 1'b0, a, 8'($random(seed)));
    endtask
    task automatic set_cfg(input logic v11, input logic sink, input logic pres, input logic [7:0] code,
                           input logic [3:0] total);
        cfg <= '{v11, sink, 1'($random(seed)), code, pres, 1'($random(seed)), 1'($random(seed)),
                 8'($random(seed)), total};
        for (int i = 0; i < NP; i++) dsp_cfg[i] <= '{3'($random(seed)), 1'($random(seed)), 1'($random(seed))};
        repeat (2) src.xfer(1'b0, 1'b0, 20'($random(seed)), 8'($random(seed)));
        check14(rx0_bytes, ({6'h00, code} + 14'h0001) * 14'h0020);
        check14(rx1_bytes, pres ? ({6'h00, cfg.rx1_buffer_code} + 14'h0001) * 14'h0020 : 14'h0000);
    endtask
    // Write just ahead of each read so a leaked write shows at once
    task automatic run(input logic wr_too);
        for (int a = 0; a < 'h120; a++) begin
            if (wr_too) src.xfer(1'b0, 1'b1, 20'(a), 8'($random(seed)));
            rd(20'(a));
        end
        rd(20'hFFFFF);
        src.xfer(1'b0, 1'b0, 20'h00000, 8'h00);
    endtask
    task automatic tally_and_finish;
        repeat (2) @(posedge clk_sys);
        // A read whose answer never showed is a failure too
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("MISMATCH t=%0t %0d reads never answered", $time, exp_q.size());
        end
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        seed = 94;
        error_cnt = 0;
        checks_done = 0;
        rst_b = 1'b0;
        cfg = '0;
        for (int i = 0; i < NP; i++) dsp_cfg[i] = '0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        set_cfg(1'b1, 1'b0, 1'b1, 8'h00, 4'hF);
        run(1'b0);
        set_cfg(1'b1, 1'b0, 1'b1, 8'hFF, 4'h0);
        run(1'b1);
        set_cfg(1'b0, 1'b1, 1'b0, 8'h7F, 4'hF);
        run(1'b1);
        set_cfg(1'b1, 1'b1, 1'b1, 8'($random(seed)), 4'h9);
        run(1'b0);
        tally_and_finish;
    end
    initial begin
        #1000000;
        error_cnt++;
        $display("MISMATCH t=%0t run did not finish", $time);
        tally_and_finish;
    end
endmodule
bind rpc_cap_bank rpc_cap_bank_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus_req(bus_req), .rd_data(rd_data), .cfg(cfg), .dsp_cfg(dsp_cfg),
    .rx0_lane_buffer_bytes(rx0_lane_buffer_bytes), .rx1_lane_buffer_bytes(rx1_lane_buffer_bytes));
